// [src/nibble_gpio_map.vh]
// constants for the nibble i/o port block
// Behaviour
// - after reset, io_port_one and io_port_two pins are inputs, drivers off.
// - drive_type_sel bits 0/1 pick push-pull or open-drain for ports one/two.
// - dir_one bit n: 0 output, 1 input; resets to all ones.
// - dir_two bit n: 0 output, 1 input; resets to all ones.
// - dir_three bit n: 0 output, 1 input; resets to all ones.
// - dir_four bit n: 0 output, 1 input, per pin.
// - ports three and four reset to input and drive push-pull only.
// - port read returns pin levels; port write loads the output latch.
// - led_port_mode bit 1 picks latch output or serial port on led pins.
// - led_port_mode bit 3 picks serial rate clock/2 or clock/256.
// - port three change releases hold or interrupts only if all enables are set.
// - pin_change_enable bit n gates the event from port three pin n; the log records every pin.
// - pin changes go into a readable pin_change_log, cleared by instruction.
// - accepted interrupt clears event flag; log kept until clear, enable write, reset.
// - falling edge on a stop_wake_select pin of port three leaves stop.
// - io_port_four is plain i/o, no wake, interrupt or alternate use.
// - serial mode pins 0..3 are data out, clock out, data in, clock in.
// - log bit n is set when pin n of port three changes level.
`ifndef NIBBLE_GPIO_MAP_VH
`define NIBBLE_GPIO_MAP_VH

// write targets
`define WR_DRIVE_TYPE      4'h0
`define WR_DIR_ONE         4'h1
`define WR_DIR_TWO         4'h2
`define WR_LED_MODE        4'h3
`define WR_DIR_THREE       4'h4
`define WR_DIR_FOUR        4'h5
`define WR_CHANGE_ENABLE   4'h6
`define WR_STOP_WAKE_SEL   4'h7
`define WR_LATCH_ONE       4'h8
`define WR_LATCH_TWO       4'h9
`define WR_LATCH_THREE     4'hA
`define WR_LATCH_FOUR      4'hB
`define WR_LATCH_INTERNAL  4'hC

// read targets
`define RD_PORT_ONE        3'h0
`define RD_PORT_TWO        3'h1
`define RD_PORT_THREE      3'h2
`define RD_PORT_FOUR       3'h3
`define RD_CHANGE_LOG      3'h4

// field positions
`define DRV_OD_ONE_BIT     0
`define DRV_OD_TWO_BIT     1
`define LED_SERIAL_BIT     1
`define LED_SLOW_RATE_BIT  3
`define SER_DOUT_PIN       0
`define SER_SERIAL_CLK_OUT_PIN       1
`define SER_DIN_PIN        2
`define SER_SERIAL_CLK_IN_PIN       3

// reset values
`define DIR_RESET          4'hF
`define DRIVE_RESET        4'h0
`define LED_MODE_RESET     4'h0
`define ENABLE_RESET       4'h0
`define LATCH_RESET        4'h0

// serial rate divisors
`define SER_DIV_FAST       9'h002
`define SER_DIV_SLOW       9'h100

`endif

// [src/nibble_sync.v]
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none
module nibble_sync #(
   parameter WIDTH = 4
) (
   input  wire             clk_in,
   input  wire             reset_n_in,
   input  wire [WIDTH-1:0] async_in,
   output reg  [WIDTH-1:0] sync_out
);
   reg [WIDTH-1:0] meta_reg;

   // first stage feeds only the second stage
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         meta_reg <= {WIDTH{1'b0}};
         sync_out <= {WIDTH{1'b0}};
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// [src/nibble_gpio_ports.v]
// four nibble i/o ports, led output port mode and port change detection
`timescale 1ns/1ps
`default_nettype none
`include "nibble_gpio_map.vh"
module nibble_gpio_ports #(
   parameter WIDTH = 4
) (
   input  wire             clk_in,
   input  wire             reset_n_in,
   // instruction side
   input  wire             wr_en_in,
   input  wire [3:0]       wr_sel_in,
   input  wire [WIDTH-1:0] wr_data_in,
   input  wire             rd_en_in,
   input  wire [2:0]       rd_sel_in,
   output reg  [WIDTH-1:0] rd_data_out,
   input  wire             log_clear_in,
   input  wire             irq_ack_in,
   input  wire             hold_wake_enable_in,
   input  wire             irq_enable_in,
   output reg              event_flag_out,
   output reg              irq_req_out,
   output reg              hold_release_out,
   output reg              stop_wake_out,
   // serial engine side
   input  wire             serial_data_out_in,
   input  wire             serial_clk_out_in,
   output reg              serial_data_in_out,
   output reg              serial_clk_in_out,
   output reg              serial_mode_out,
   output reg              serial_tick_out,
   // io_port_one
   input  wire [WIDTH-1:0] port_one_in,
   output reg  [WIDTH-1:0] port_one_out,
   output reg  [WIDTH-1:0] port_one_oe_out,
   // io_port_two
   input  wire [WIDTH-1:0] port_two_in,
   output reg  [WIDTH-1:0] port_two_out,
   output reg  [WIDTH-1:0] port_two_oe_out,
   // io_port_three_wake
   input  wire [WIDTH-1:0] port_three_in,
   output reg  [WIDTH-1:0] port_three_out,
   output reg  [WIDTH-1:0] port_three_oe_out,
   // io_port_four
   input  wire [WIDTH-1:0] port_four_in,
   output reg  [WIDTH-1:0] port_four_out,
   output reg  [WIDTH-1:0] port_four_oe_out,
   // led_output_port
   input  wire [WIDTH-1:0] led_port_in,
   output reg  [WIDTH-1:0] led_port_out,
   output reg  [WIDTH-1:0] led_port_oe_out,
   output reg  [WIDTH-1:0] led_pullup_out
);

   // ************************************************************
   // functions
   // ************************************************************

   // pin level driven for a given latch and drive type
   function [WIDTH-1:0] drive_level;
      input [WIDTH-1:0] latch;
      input             open_drain;
      begin
         drive_level = open_drain ? {WIDTH{1'b0}} : latch;
      end
   endfunction

   // enable: open drain only pulls low, so a latch one releases the pin
   function [WIDTH-1:0] drive_enable;
      input [WIDTH-1:0] latch;
      input [WIDTH-1:0] dir;
      input             open_drain;
      begin
         drive_enable = open_drain ? (~dir & ~latch) : ~dir;
      end
   endfunction

   // ************************************************************
   // mode registers and output latches
   // ************************************************************

   reg [WIDTH-1:0] drive_type_sel_reg;
   reg [WIDTH-1:0] dir_one_reg;
   reg [WIDTH-1:0] dir_two_reg;
   reg [WIDTH-1:0] led_port_mode_reg;
   reg [WIDTH-1:0] dir_three_reg;
   reg [WIDTH-1:0] dir_four_reg;
   reg [WIDTH-1:0] pin_change_enable_reg;
   reg [WIDTH-1:0] stop_wake_select_reg;
   reg [WIDTH-1:0] latch_one_reg;
   reg [WIDTH-1:0] latch_two_reg;
   reg [WIDTH-1:0] latch_three_reg;
   reg [WIDTH-1:0] latch_four_reg;
   reg [WIDTH-1:0] internal_latch_out_reg;

   wire enable_write;
   assign enable_write = wr_en_in && (wr_sel_in == `WR_CHANGE_ENABLE);

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         drive_type_sel_reg     <= `DRIVE_RESET;
         dir_one_reg            <= `DIR_RESET;
         dir_two_reg            <= `DIR_RESET;
         led_port_mode_reg      <= `LED_MODE_RESET;
         dir_three_reg          <= `DIR_RESET;
         dir_four_reg           <= `DIR_RESET;
         pin_change_enable_reg  <= `ENABLE_RESET;
         stop_wake_select_reg   <= `ENABLE_RESET;
         latch_one_reg          <= `LATCH_RESET;
         latch_two_reg          <= `LATCH_RESET;
         latch_three_reg        <= `LATCH_RESET;
         latch_four_reg         <= `LATCH_RESET;
         internal_latch_out_reg <= `LATCH_RESET;
      end else if (wr_en_in) begin
         case (wr_sel_in)
            `WR_DRIVE_TYPE: begin
               drive_type_sel_reg <= wr_data_in;
            end
            `WR_DIR_ONE: begin
               dir_one_reg <= wr_data_in;
            end
            `WR_DIR_TWO: begin
               dir_two_reg <= wr_data_in;
            end
            `WR_LED_MODE: begin
               led_port_mode_reg <= wr_data_in;
            end
            `WR_DIR_THREE: begin
               dir_three_reg <= wr_data_in;
            end
            `WR_DIR_FOUR: begin
               dir_four_reg <= wr_data_in;
            end
            `WR_CHANGE_ENABLE: begin
               pin_change_enable_reg <= wr_data_in;
            end
            `WR_STOP_WAKE_SEL: begin
               stop_wake_select_reg <= wr_data_in;
            end
            `WR_LATCH_ONE: begin
               latch_one_reg <= wr_data_in;
            end
            `WR_LATCH_TWO: begin
               latch_two_reg <= wr_data_in;
            end
            `WR_LATCH_THREE: begin
               latch_three_reg <= wr_data_in;
            end
            `WR_LATCH_FOUR: begin
               latch_four_reg <= wr_data_in;
            end
            `WR_LATCH_INTERNAL: begin
               internal_latch_out_reg <= wr_data_in;
            end
            default: begin
               latch_four_reg <= latch_four_reg;
            end
         endcase
      end
   end

   // ************************************************************
   // pin input synchronisers
   // ************************************************************

   wire [WIDTH-1:0] one_sync;
   wire [WIDTH-1:0] two_sync;
   wire [WIDTH-1:0] three_sync;
   wire [WIDTH-1:0] four_sync;
   wire [WIDTH-1:0] led_sync;

   nibble_sync #(.WIDTH(WIDTH)) sync_one (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .async_in   (port_one_in),
      .sync_out   (one_sync)
   );

   nibble_sync #(.WIDTH(WIDTH)) sync_two (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .async_in   (port_two_in),
      .sync_out   (two_sync)
   );

   nibble_sync #(.WIDTH(WIDTH)) sync_three (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .async_in   (port_three_in),
      .sync_out   (three_sync)
   );

   nibble_sync #(.WIDTH(WIDTH)) sync_four (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .async_in   (port_four_in),
      .sync_out   (four_sync)
   );

   nibble_sync #(.WIDTH(WIDTH)) sync_led (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .async_in   (led_port_in),
      .sync_out   (led_sync)
   );

   // ************************************************************
   // port three change detection
   // ************************************************************

   reg  [WIDTH-1:0] three_prev_reg;
   reg              three_primed_reg;
   reg  [WIDTH-1:0] pin_change_log_reg;
   reg  [WIDTH-1:0] pin_change_log_next;
   wire [WIDTH-1:0] pin_changed;
   wire [WIDTH-1:0] pin_fell;
   wire             qualified_change;

   // the first sample after reset only primes the history, but the synchroniser
   // still holds its reset value then, so a pin high through reset is taken as a change
   // either edge counts
   assign pin_changed = three_primed_reg ?
                        (three_sync ^ three_prev_reg) : {WIDTH{1'b0}};
   assign pin_fell    = three_primed_reg ?
                        (three_prev_reg & ~three_sync) : {WIDTH{1'b0}};
   assign qualified_change = |(pin_changed & pin_change_enable_reg);

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         three_prev_reg   <= {WIDTH{1'b0}};
         three_primed_reg <= 1'b0;
      end else begin
         three_prev_reg   <= three_sync;
         three_primed_reg <= 1'b1;
      end
   end

   always @* begin
      pin_change_log_next = pin_change_log_reg;
      // cleared only by clear, enable write or reset
      if (log_clear_in || enable_write) begin
         pin_change_log_next = {WIDTH{1'b0}};
      end
      pin_change_log_next = pin_change_log_next | pin_changed;
   end

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         pin_change_log_reg <= {WIDTH{1'b0}};
      end else begin
         pin_change_log_reg <= pin_change_log_next;
      end
   end

   // ************************************************************
   // event flag, interrupt, hold and stop wake
   // ************************************************************

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         event_flag_out   <= 1'b0;
         irq_req_out      <= 1'b0;
         hold_release_out <= 1'b0;
         stop_wake_out    <= 1'b0;
      end else begin
         if (qualified_change) begin
            event_flag_out <= 1'b1;
         end else if (irq_ack_in) begin
            event_flag_out <= 1'b0;
         end
         irq_req_out      <= qualified_change && irq_enable_in &&
                             hold_wake_enable_in;
         hold_release_out <= qualified_change && hold_wake_enable_in &&
                             irq_enable_in;
         stop_wake_out    <= |(pin_fell & stop_wake_select_reg);
      end
   end

   // ************************************************************
   // serial rate divider
   // ************************************************************

   reg  [8:0] rate_count_reg;
   wire [8:0] rate_limit;
   wire       serial_mode;

   assign serial_mode = led_port_mode_reg[`LED_SERIAL_BIT];
   assign rate_limit  = led_port_mode_reg[`LED_SLOW_RATE_BIT] ?
                        `SER_DIV_SLOW : `SER_DIV_FAST;

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rate_count_reg  <= 9'h000;
         serial_tick_out <= 1'b0;
      end else if (!serial_mode) begin
         rate_count_reg  <= 9'h000;
         serial_tick_out <= 1'b0;
      end else if (rate_count_reg >= rate_limit - 9'h001) begin
         rate_count_reg  <= 9'h000;
         serial_tick_out <= 1'b1;
      end else begin
         rate_count_reg  <= rate_count_reg + 9'h001;
         serial_tick_out <= 1'b0;
      end
   end

   // ************************************************************
   // pin drivers
   // ************************************************************

   wire od_one;
   wire od_two;

   assign od_one = drive_type_sel_reg[`DRV_OD_ONE_BIT];
   assign od_two = drive_type_sel_reg[`DRV_OD_TWO_BIT];

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         port_one_out       <= {WIDTH{1'b0}};
         port_one_oe_out    <= {WIDTH{1'b0}};
         port_two_out       <= {WIDTH{1'b0}};
         port_two_oe_out    <= {WIDTH{1'b0}};
         port_three_out     <= {WIDTH{1'b0}};
         port_three_oe_out  <= {WIDTH{1'b0}};
         port_four_out      <= {WIDTH{1'b0}};
         port_four_oe_out   <= {WIDTH{1'b0}};
         led_port_out       <= {WIDTH{1'b0}};
         led_port_oe_out    <= {WIDTH{1'b0}};
         led_pullup_out     <= {WIDTH{1'b0}};
         serial_mode_out    <= 1'b0;
         serial_data_in_out <= 1'b0;
         serial_clk_in_out  <= 1'b0;
      end else begin
         port_one_out      <= drive_level(latch_one_reg, od_one);
         port_one_oe_out   <= drive_enable(latch_one_reg, dir_one_reg,
                                           od_one);
         port_two_out      <= drive_level(latch_two_reg, od_two);
         port_two_oe_out   <= drive_enable(latch_two_reg, dir_two_reg,
                                           od_two);
         port_three_out    <= latch_three_reg;
         port_three_oe_out <= ~dir_three_reg;
         port_four_out     <= latch_four_reg;
         port_four_oe_out  <= ~dir_four_reg;
         serial_mode_out   <= serial_mode;
         serial_data_in_out <= led_sync[`SER_DIN_PIN];
         serial_clk_in_out  <= led_sync[`SER_SERIAL_CLK_IN_PIN];
         if (serial_mode) begin
            // serial pin map, data in pulled up
            led_port_out    <= {2'b00, serial_clk_out_in,
                                serial_data_out_in};
            led_port_oe_out <= 4'h3;
            led_pullup_out  <= 4'h4;
         end else begin
            led_port_out    <= internal_latch_out_reg;
            led_port_oe_out <= {WIDTH{1'b1}};
            led_pullup_out  <= {WIDTH{1'b0}};
         end
      end
   end

   // ************************************************************
   // read path
   // ************************************************************

   reg [WIDTH-1:0] rd_next;

   always @* begin
      case (rd_sel_in)
         `RD_PORT_ONE: begin
            rd_next = one_sync;
         end
         `RD_PORT_TWO: begin
            rd_next = two_sync;
         end
         `RD_PORT_THREE: begin
            rd_next = three_sync;
         end
         `RD_PORT_FOUR: begin
            rd_next = four_sync;
         end
         `RD_CHANGE_LOG: begin
            rd_next = pin_change_log_reg;
         end
         default: begin
            rd_next = {WIDTH{1'b0}};
         end
      endcase
   end

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rd_data_out <= {WIDTH{1'b0}};
      end else if (rd_en_in) begin
         rd_data_out <= rd_next;
      end
   end

endmodule
`default_nettype wire

// [src/_end_placeholder_unused.v]
// spare file, holds no logic

// [verification/nibble_gpio_ports_props.sv]
// assertion checker for the nibble i/o port block
`timescale 1ns/1ps
`default_nettype none
module nibble_gpio_ports_props (
   input wire logic       clk_in,
   input wire logic       reset_n_in,
   input wire logic       wr_en_in,
   input wire logic [3:0] wr_sel_in,
   input wire logic       rd_en_in,
   input wire logic [3:0] rd_data_out,
   input wire logic       irq_ack_in,
   input wire logic       hold_wake_enable_in,
   input wire logic       irq_enable_in,
   input wire logic       event_flag_out,
   input wire logic       irq_req_out,
   input wire logic       hold_release_out,
   input wire logic       serial_mode_out,
   input wire logic       serial_tick_out,
   input wire logic [3:0] led_port_oe_out,
   input wire logic [3:0] led_pullup_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!reset_n_in);
   // ****
   // tick gap helper
   // ****
   // skip the partial gap after a rate write
   logic [8:0] gap_reg;
   logic [1:0] seen_reg;
   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         gap_reg  <= 9'h001;
         seen_reg <= 2'h0;
      end else begin
         if (serial_tick_out)
            gap_reg <= 9'h001;
         else if (gap_reg != 9'h1ff)
            gap_reg <= gap_reg + 9'h001;
         if (wr_en_in && wr_sel_in == 4'h3)
            seen_reg <= 2'h0;
         else if (serial_tick_out && seen_reg != 2'h2)
            seen_reg <= seen_reg + 2'h1;
      end
   end
   // ****
   // properties
   // ****
   // both enables needed
   a_irq_needs_en: assert property (
      irq_req_out |-> $past(irq_enable_in && hold_wake_enable_in))
      else $error("irq pulse without both enables");
   a_hold_with_irq: assert property (
      irq_req_out == hold_release_out)
      else $error("hold release and irq pulse differ");
   a_irq_sets_flag: assert property (
      irq_req_out |-> event_flag_out)
      else $error("irq pulse without event flag");
   a_flag_sticky: assert property (
      $past(event_flag_out) && !$past(irq_ack_in) |-> event_flag_out)
      else $error("event flag dropped without ack");
   a_ack_clears: assert property (
      irq_ack_in && irq_enable_in && hold_wake_enable_in
      |=> !event_flag_out || irq_req_out)
      else $error("ack did not clear event flag");
   a_read_holds: assert property (
      !rd_en_in |=> $stable(rd_data_out))
      else $error("read data changed without read");
   a_tick_parallel: assert property (
      !serial_mode_out && $past(!serial_mode_out) |-> !serial_tick_out)
      else $error("serial tick in parallel mode");
   a_tick_period: assert property (
      serial_tick_out && seen_reg == 2'h2
      |-> gap_reg == 9'h002 || gap_reg == 9'h100)
      else $error("serial tick gap not 2 or 256");
   a_serial_pins: assert property (
      serial_mode_out [*3] |-> led_port_oe_out == 4'h3 && led_pullup_out[2])
      else $error("serial mode led pin drive wrong");
   a_parallel_oe: assert property (
      !serial_mode_out [*3] |-> led_port_oe_out == 4'hF)
      else $error("parallel mode led pins not driven");
   c_irq: cover property (irq_req_out);
   c_ack: cover property (irq_ack_in && event_flag_out);
   c_tick: cover property (serial_tick_out && seen_reg == 2'h2);
endmodule

bind nibble_gpio_ports nibble_gpio_ports_props nibble_gpio_ports_props_inst (
   .clk_in, .reset_n_in, .wr_en_in, .wr_sel_in, .rd_en_in, .rd_data_out,
   .irq_ack_in, .hold_wake_enable_in, .irq_enable_in, .event_flag_out,
   .irq_req_out, .hold_release_out, .serial_mode_out, .serial_tick_out,
   .led_port_oe_out, .led_pullup_out
);
`default_nettype wire

// [verification/pin_board.sv]
// board model on the far side of one nibble port's pins
`timescale 1ns/1ps
`default_nettype none
module pin_board (
   input  wire logic [3:0] drv_out_in,
   input  wire logic [3:0] drv_oe_in,
   input  wire logic [3:0] board_in,
   output wire logic [3:0] level_out
);
   // the board drives any pin the device leaves undriven
   assign level_out = (drv_out_in & drv_oe_in) | (board_in & ~drv_oe_in);
endmodule
`default_nettype wire

// [verification/tb_nibble_gpio_ports.sv]
// self-checking bench for the nibble i/o port block
`timescale 1ns/1ps
`default_nettype none
module tb_nibble_gpio_ports;
   logic       clk_in, reset_n_in, wr_en_in, rd_en_in, log_clear_in;
   logic       irq_ack_in, hold_wake_enable_in, irq_enable_in;
   logic       serial_data_out_in, serial_clk_out_in;
   logic [3:0] wr_sel_in, wr_data_in, v, pv;
   logic [2:0] rd_sel_in;
   logic [3:0] brd [0:4];
   wire  [3:0] pin [0:4];
   wire  [3:0] po [0:4];
   wire  [3:0] pe [0:4];
   wire  [3:0] rd_data_out, led_pullup_out;
   wire        event_flag_out, irq_req_out, hold_release_out, stop_wake_out;
   wire        serial_data_in_out, serial_clk_in_out, serial_mode_out;
   wire        serial_tick_out;
   int         n_fail, checked, i, g;
   typedef struct packed {
      logic [3:0] drv; logic [1:0] p; logic [3:0] dir, lat, oe, out, rd;
   } row_t;
   row_t rows [0:5] = '{'{4'h0, 2'h0, 4'hA, 4'h3, 4'h5, 4'h3, 4'h1},
      '{4'h1, 2'h0, 4'h0, 4'hC, 4'h3, 4'h0, 4'h4},
      '{4'h0, 2'h1, 4'h0, 4'h9, 4'hF, 4'h9, 4'h9},
      '{4'h2, 2'h1, 4'h6, 4'h2, 4'h9, 4'h0, 4'h4},
      '{4'h3, 2'h2, 4'h0, 4'h5, 4'hF, 4'h5, 4'h5},
      '{4'h3, 2'h3, 4'h3, 4'hE, 4'hC, 4'hE, 4'hD}};
   nibble_gpio_ports nibble_gpio_ports_inst (
      .clk_in, .reset_n_in, .wr_en_in, .wr_sel_in, .wr_data_in, .rd_en_in,
      .rd_sel_in, .rd_data_out, .log_clear_in, .irq_ack_in,
      .hold_wake_enable_in, .irq_enable_in, .event_flag_out, .irq_req_out,
      .hold_release_out, .stop_wake_out, .serial_data_out_in,
      .serial_clk_out_in, .serial_data_in_out, .serial_clk_in_out,
      .serial_mode_out, .serial_tick_out,
      .port_one_in(pin[0]), .port_one_out(po[0]), .port_one_oe_out(pe[0]),
      .port_two_in(pin[1]), .port_two_out(po[1]), .port_two_oe_out(pe[1]),
      .port_three_in(pin[2]), .port_three_out(po[2]),
      .port_three_oe_out(pe[2]), .port_four_in(pin[3]),
      .port_four_out(po[3]), .port_four_oe_out(pe[3]),
      .led_port_in(pin[4]), .led_port_out(po[4]), .led_port_oe_out(pe[4]),
      .led_pullup_out);
   for (genvar k = 0; k < 5; k++) begin : g_board
      pin_board pin_board_inst (.drv_out_in(po[k]), .drv_oe_in(pe[k]),
         .board_in(brd[k]), .level_out(pin[k]));
   end
   // ****
   // tasks
   // ****
   task automatic chk(string nm, logic [3:0] exp, logic [3:0] got);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic idle(int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic wr(logic [3:0] sel, logic [3:0] d);
      @(posedge clk_in);
      wr_en_in <= 1'b1;
      wr_sel_in <= sel;
      wr_data_in <= d;
      @(posedge clk_in);
      wr_en_in <= 1'b0;
   endtask
   task automatic rd(logic [2:0] sel);
      @(posedge clk_in);
      rd_en_in <= 1'b1;
      rd_sel_in <= sel;
      @(posedge clk_in);
      rd_en_in <= 1'b0;
      #1 v = rd_data_out;
   endtask
   // pv gathers irq, hold and stop pulses seen, then the event flag
   task automatic poke(logic [3:0] lvl);
      @(posedge clk_in);
      brd[2] <= lvl;
      pv = 4'h0;
      repeat (8) begin
         @(posedge clk_in);
         #1;
         pv = pv | {1'b0, stop_wake_out, hold_release_out, irq_req_out};
      end
      pv[3] = event_flag_out;
   endtask
   task automatic pulse_ack();
      @(posedge clk_in);
      irq_ack_in <= 1'b1;
      @(posedge clk_in);
      irq_ack_in <= 1'b0;
   endtask
   task automatic tick_gap();
      repeat (2) begin
         g = 0;
         do begin
            idle(1);
            g++;
         end while (serial_tick_out !== 1'b1 && g < 600);
      end
   endtask
   task automatic rst_test(int n);
      @(posedge clk_in);
      reset_n_in <= 1'b0;
      repeat (n) @(posedge clk_in);
      for (i = 0; i < 4; i++) chk("oe in reset", 4'h0, pe[i]);
      reset_n_in <= 1'b1;
      idle(3);
      for (i = 0; i < 4; i++) chk("oe after reset", 4'h0, pe[i]);
      chk("led oe", 4'hF, pe[4]);
      rd(3'h0);
      chk("port one read", 4'h5, v);
      $display("test reset done");
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ****
   // stimulus
   // ****
   initial begin
      clk_in = 1'b0;
      forever #2.5 clk_in = ~clk_in;
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      n_fail++;
      close_out();
   end
   initial begin
      {reset_n_in, wr_en_in, rd_en_in, log_clear_in, irq_ack_in} = 5'h00;
      {hold_wake_enable_in, irq_enable_in} = 2'h0;
      {serial_data_out_in, serial_clk_out_in} = 2'h0;
      {wr_sel_in, wr_data_in, rd_sel_in} = 11'h000;
      for (i = 0; i < 5; i++) brd[i] = (i == 2 || i == 4) ? 4'h0 : 4'h5;
      rst_test(20);
      for (int r = 0; r < 6; r++) begin
         wr(4'h0, rows[r].drv);
         wr(4'h8 + {2'h0, rows[r].p}, rows[r].lat);
         wr({2'h0, rows[r].p} + (rows[r].p < 2 ? 4'h1 : 4'h2), rows[r].dir);
         idle(4);
         chk("drive enable", rows[r].oe, pe[rows[r].p]);
         chk("drive value", rows[r].out & rows[r].oe,
             po[rows[r].p] & pe[rows[r].p]);
         rd({1'b0, rows[r].p});
         chk("pin read", rows[r].rd, v);
      end
      $display("test rows done");
      wr(4'hA, 4'h0);
      wr(4'h4, 4'hF);
      hold_wake_enable_in <= 1'b1;
      irq_enable_in <= 1'b1;
      wr(4'h7, 4'h1);
      wr(4'h6, 4'h1);
      rd(3'h4);
      chk("log after enable write", 4'h0, v);
      poke(4'h1);
      chk("rise enabled pin", 4'hB, pv);
      poke(4'h3);
      chk("rise masked pin", 4'h8, pv);
      poke(4'h2);
      chk("fall stop pin", 4'hF, pv);
      poke(4'h6);
      chk("rise unselected", 4'h8, pv);
      rd(3'h4);
      chk("change log", 4'h7, v);
      pulse_ack();
      idle(2);
      chk("flag after ack", 4'h0, {3'h0, event_flag_out});
      rd(3'h4);
      chk("log kept on ack", 4'h7, v);
      @(posedge clk_in);
      log_clear_in <= 1'b1;
      @(posedge clk_in);
      log_clear_in <= 1'b0;
      rd(3'h4);
      chk("log cleared", 4'h0, v);
      irq_enable_in <= 1'b0;
      poke(4'h7);
      chk("irq disabled", 4'h8, pv);
      wr(4'h6, 4'h1);
      rd(3'h4);
      chk("log cleared by enable", 4'h0, v);
      pulse_ack();
      wr(4'h5, 4'hF);
      @(posedge clk_in);
      brd[3] <= 4'hA;
      idle(6);
      rd(3'h4);
      chk("port four no log", 4'h0, v);
      rd(3'h3);
      chk("port four read", 4'hA, v);
      $display("test change done");
      wr(4'h3, 4'h2);
      @(posedge clk_in);
      brd[4] <= 4'h4;
      serial_data_out_in <= 1'b1;
      idle(5);
      chk("serial mode", 4'h1, {3'h0, serial_mode_out});
      chk("serial oe", 4'h3, pe[4]);
      chk("din pull-up", 4'h4, led_pullup_out);
      chk("serial out pins", 4'h1, po[4] & 4'h3);
      chk("serial in", 4'h1,
          {2'h0, serial_clk_in_out, serial_data_in_out});
      tick_gap();
      chk("fast tick gap", 4'h1, {3'h0, g == 2});
      wr(4'h3, 4'hA);
      tick_gap();
      chk("slow tick gap", 4'h1, {3'h0, g == 256});
      wr(4'h3, 4'h0);
      wr(4'hC, 4'h9);
      idle(4);
      chk("led latch out", 4'h9, po[4]);
      chk("tick off", 4'h0, {3'h0, serial_tick_out});
      $display("test serial done");
      rst_test(2);
      close_out();
   end
endmodule
`default_nettype wire
